// *** fasr_pkg.sv ***
// fasr_pkg: constants and carriers for the flash status-polling controller.
// assumes a 20 MHz pclk and an asynchronous x16 parallel flash on the far side.
package fasr_pkg;
    localparam int CLK_MHZ = 20;
    // bus timing in ns; least times, rounded up to whole cycles
    localparam int T_ACC_NS = 90;
    localparam int T_WP_NS = 35;
    localparam int T_REC_NS = 35;
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;

    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;

    // software register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_RDATA = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // status word views: bits 15:8 and 0 reserved; polling also hides bit 4
    localparam logic [15:0] SR_MASK = 16'h00FE;
    localparam logic [15:0] POLL_MASK = 16'h00EE;
    localparam logic [15:0] SR_RESET = 16'h0080;
    localparam int SR_READY_BIT = 7;
    localparam int POLL_BIT = 7;
    localparam int SR_ESUSP_BIT = 6;
    localparam int SR_EFAIL_BIT = 5;
    localparam int SR_PFAIL_BIT = 4;
    localparam int SR_ABORT_BIT = 3;
    localparam int SR_PSUSP_BIT = 2;
    localparam int SR_LOCK_BIT = 1;

    // STAT layout
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_SR_LSB = 16;

    typedef enum logic [1:0] {
        FASR_OP_WRITE,
        FASR_OP_READ,
        FASR_OP_STATUS,
        FASR_OP_POLL
    } fasr_op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe_n;
    } fasr_pins_t;
endpackage : fasr_pkg

// *** fasr_ctrl.sv ***
// fasr_ctrl: host controller that drives the flash pins, reads its status
// register and runs data polling on line 7, under APB software control.
// assumes the flash answers within the fixed access time and needs no clock.
`timescale 1ns/1ps
module fasr_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [fasr_pkg::DATA_W-1:0] flash_dq_in,
    output fasr_pkg::fasr_pins_t flash_pins
);
    typedef enum logic [2:0] {
        FASR_IDLE,
        FASR_WR_PULSE,
        FASR_WR_REC,
        FASR_RD_ACC,
        FASR_RD_REC
    } fasr_state_t;

    function automatic logic reg_mapped(input logic [7:0] a);
        return a == fasr_pkg::OFS_CTRL || a == fasr_pkg::OFS_ADDR
            || a == fasr_pkg::OFS_WDATA || a == fasr_pkg::OFS_RDATA
            || a == fasr_pkg::OFS_STAT;
    endfunction : reg_mapped

    fasr_state_t state, next_state;
    fasr_pkg::fasr_op_t op, next_op;
    logic [3:0] cnt, next_cnt;
    logic final_rd, next_final_rd;
    logic busy, next_busy;
    logic done, next_done;
    logic [fasr_pkg::ADDR_W-1:0] addr, next_addr;
    logic [fasr_pkg::DATA_W-1:0] wdata, next_wdata;
    logic [fasr_pkg::DATA_W-1:0] rdata, next_rdata;
    logic [fasr_pkg::DATA_W-1:0] sr, next_sr;
    logic [fasr_pkg::DATA_W-1:0] rd_word, next_rd_word;
    fasr_pkg::fasr_pins_t next_pins;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic wr_en;
    logic start;

    // status fields 6..1 as last read with the ready bit high; the ready bit follows every status read
    logic device_ready_flag;
    logic erase_suspended_flag;
    logic erase_result_flag;
    logic program_result_flag;
    logic buffer_abort_flag;
    logic program_suspended_flag;
    logic sector_locked_flag;

    // named view of the captured word; no state of its own
    always_comb begin
        device_ready_flag = sr[fasr_pkg::SR_READY_BIT];
        erase_suspended_flag = sr[fasr_pkg::SR_ESUSP_BIT];
        erase_result_flag = sr[fasr_pkg::SR_EFAIL_BIT];
        program_result_flag = sr[fasr_pkg::SR_PFAIL_BIT];
        buffer_abort_flag = sr[fasr_pkg::SR_ABORT_BIT];
        program_suspended_flag = sr[fasr_pkg::SR_PSUSP_BIT];
        sector_locked_flag = sr[fasr_pkg::SR_LOCK_BIT];
    end

    // apb register group
    always_comb begin
        wr_en = psel && penable && pready && pwrite && reg_mapped(paddr);
        next_addr = addr;
        next_wdata = wdata;
        // address and data are held while an access runs
        if (wr_en && paddr == fasr_pkg::OFS_ADDR && !busy) begin
            next_addr = pwdata[fasr_pkg::ADDR_W-1:0];
        end
        if (wr_en && paddr == fasr_pkg::OFS_WDATA && !busy) begin
            next_wdata = pwdata[fasr_pkg::DATA_W-1:0];
        end

        // zero-wait slave: answer in the first access cycle
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !reg_mapped(paddr);
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                fasr_pkg::OFS_CTRL: next_prdata = {30'h0000_0000, op};
                fasr_pkg::OFS_ADDR: next_prdata = 32'(addr);
                fasr_pkg::OFS_WDATA: next_prdata = 32'(wdata);
                fasr_pkg::OFS_RDATA: next_prdata = 32'(rdata);
                fasr_pkg::OFS_STAT: begin
                    next_prdata[fasr_pkg::STAT_BUSY] = busy;
                    next_prdata[fasr_pkg::STAT_DONE] = done;
                    // reserved bit 0 of the word never reaches software
                    next_prdata[fasr_pkg::STAT_SR_LSB +: 8] = {device_ready_flag,
                        erase_suspended_flag, erase_result_flag, program_result_flag,
                        buffer_abort_flag, program_suspended_flag, sector_locked_flag, 1'b0};
                end
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        start = wr_en && paddr == fasr_pkg::OFS_CTRL && !busy;
        next_state = state;
        next_op = op;
        next_cnt = cnt;
        next_final_rd = final_rd;
        next_busy = busy;
        next_done = done;
        next_rdata = rdata;
        next_sr = sr;
        next_rd_word = rd_word;
        next_pins = flash_pins;

        // one flash access at a time; every op ends in idle with done set
        unique case (state)
            FASR_IDLE: begin
                if (start) begin
                    next_op = fasr_pkg::fasr_op_t'(pwdata[1:0]);
                    next_busy = 1'b1;
                    next_done = 1'b0;
                    next_final_rd = 1'b0;
                    next_pins.addr = addr;
                    next_pins.ce_n = 1'b0;
                    if (fasr_pkg::fasr_op_t'(pwdata[1:0]) == fasr_pkg::FASR_OP_WRITE
                        || fasr_pkg::fasr_op_t'(pwdata[1:0]) == fasr_pkg::FASR_OP_STATUS) begin
                        next_state = FASR_WR_PULSE;
                        next_cnt = 4'(fasr_pkg::WP_CYC);
                        next_pins.we_n = 1'b0;
                        next_pins.dq_out = wdata;
                        next_pins.dq_oe_n = 1'b0;
                    end else begin
                        next_state = FASR_RD_ACC;
                        next_cnt = 4'(fasr_pkg::ACC_CYC);
                        next_pins.oe_n = 1'b0;
                    end
                end
            end
            FASR_WR_PULSE: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    // rising write strobe ends the command; polling counts from here
                    next_pins.we_n = 1'b1;
                    next_pins.ce_n = 1'b1;
                    next_state = FASR_WR_REC;
                    next_cnt = 4'(fasr_pkg::REC_CYC);
                end
            end
            FASR_WR_REC: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_pins.dq_oe_n = 1'b1;
                    if (op == fasr_pkg::FASR_OP_STATUS) begin
                        // read follows at once: the overlay lasts for one read only
                        next_state = FASR_RD_ACC;
                        next_cnt = 4'(fasr_pkg::ACC_CYC);
                        next_pins.ce_n = 1'b0;
                        next_pins.oe_n = 1'b0;
                    end else begin
                        next_state = FASR_IDLE;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                    end
                end
            end
            FASR_RD_ACC: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_rd_word = flash_dq_in;
                    next_pins.oe_n = 1'b1;
                    next_pins.ce_n = 1'b1;
                    next_state = FASR_RD_REC;
                    next_cnt = 4'(fasr_pkg::REC_CYC);
                end
            end
            FASR_RD_REC: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_state = FASR_IDLE;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    unique case (op)
                        fasr_pkg::FASR_OP_READ: next_rdata = rd_word;
                        fasr_pkg::FASR_OP_STATUS: begin
                            next_rdata = rd_word & fasr_pkg::SR_MASK;
                            if (rd_word[fasr_pkg::SR_READY_BIT]) begin
                                // flags 6..1 kept only once ready: erase/program
                                // suspend, erase/program fail, abort, lock error
                                next_sr = rd_word & fasr_pkg::SR_MASK;
                            end else begin
                                // busy: reissue the status command and read again
                                next_sr[fasr_pkg::SR_READY_BIT] = 1'b0;
                                next_state = FASR_WR_PULSE;
                                next_busy = 1'b1;
                                next_done = 1'b0;
                                next_cnt = 4'(fasr_pkg::WP_CYC);
                                next_pins.ce_n = 1'b0;
                                next_pins.we_n = 1'b0;
                                next_pins.dq_out = wdata;
                                next_pins.dq_oe_n = 1'b0;
                            end
                        end
                        fasr_pkg::FASR_OP_POLL: begin
                            if (final_rd) begin
                                next_rdata = rd_word;
                            end else begin
                                // same word at any address while busy; only line 7
                                // is judged, against the true value in wdata[7]
                                next_rdata = rd_word & fasr_pkg::POLL_MASK;
                                // true value on line 7 ends polling (program bit or
                                // erase 1); next read takes real data
                                if (rd_word[fasr_pkg::POLL_BIT]
                                    == wdata[fasr_pkg::POLL_BIT]) begin
                                    next_final_rd = 1'b1;
                                end
                                // no time limit: protected-sector polls also end only when line 7 shows the true value
                                next_state = FASR_RD_ACC;
                                next_busy = 1'b1;
                                next_done = 1'b0;
                                next_cnt = 4'(fasr_pkg::ACC_CYC);
                                next_pins.ce_n = 1'b0;
                                next_pins.oe_n = 1'b0;
                            end
                        end
                        default: next_rdata = rd_word;
                    endcase
                end
            end
            default: next_state = FASR_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr <= '0;
            wdata <= 16'h0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            addr <= next_addr;
            wdata <= next_wdata;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= FASR_IDLE;
            op <= fasr_pkg::FASR_OP_WRITE;
            cnt <= 4'h0;
            final_rd <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 16'h0000;
            sr <= fasr_pkg::SR_RESET;
            rd_word <= 16'h0000;
            flash_pins <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                            dq_out: 16'h0000, dq_oe_n: 1'b1};
        end else begin
            state <= next_state;
            op <= next_op;
            cnt <= next_cnt;
            final_rd <= next_final_rd;
            busy <= next_busy;
            done <= next_done;
            rdata <= next_rdata;
            sr <= next_sr;
            rd_word <= next_rd_word;
            flash_pins <= next_pins;
        end
    end
endmodule : fasr_ctrl

// *** fasr_ctrl_properties.sv ***
// fasr_ctrl_checker: port-level timing checks, bound to fasr_ctrl.
// assumes one pclk domain and presetn active low.
`timescale 1ns/1ps
module fasr_ctrl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire fasr_pkg::fasr_pins_t flash_pins
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && !penable |=> pready && penable)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_in_access_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside access");
    strobe_width_a: assert property ($fell(flash_pins.we_n) |=> flash_pins.we_n)
        else $error("write strobe not one cycle");
    write_drive_a: assert property (!flash_pins.we_n |-> !flash_pins.dq_oe_n && flash_pins.oe_n)
        else $error("write strobe without data");
    read_width_a: assert property ($fell(flash_pins.oe_n) |-> !flash_pins.oe_n [*2] ##1 flash_pins.oe_n)
        else $error("read access length wrong");
    read_float_a: assert property (!flash_pins.oe_n |-> flash_pins.dq_oe_n && !flash_pins.ce_n)
        else $error("dq driven during read");
    addr_hold_a: assert property (!flash_pins.ce_n && !$past(flash_pins.ce_n) |-> $stable(flash_pins.addr))
        else $error("address moved in access");
endmodule : fasr_ctrl_checker

bind fasr_ctrl fasr_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .flash_pins);

// *** fasr_flash_model.sv ***
// fasr_flash_model: behavioural x16 flash with status word and line 7 polling.
// assumes the controller's pin struct; clockless, reacts to strobe edges.
`timescale 1ns/1ps
module fasr_flash_model (
    input wire fasr_pkg::fasr_pins_t pins,
    output logic [15:0] dq
);
    logic [15:0] arr [16] = '{default: 16'h00C0};
    logic [15:0] pd = 16'h0000, last = 16'h0000, dq_now;
    logic [7:0] sr = 8'h80;
    logic armed = 1'b0, smode = 1'b0, kerase = 1'b0, lock = 1'b0;
    logic we_q = 1'b1, oe_q = 1'b1;
    int busy = 0;
    // one process owns all state, so no variable has two writers
    always @(pins.we_n, pins.oe_n) begin
        // commands take effect on the strobe's rising edge
        if (pins.we_n === 1'b1 && we_q === 1'b0) begin
            if (armed) begin
                pd = pins.dq_out;
                arr[pins.addr[3:0]] = pd;
                armed = 1'b0;
                kerase = 1'b0;
                busy = 3;
            end else begin
                case (pins.dq_out[7:0])
                    8'hA0: armed = 1'b1;
                    8'h30: begin
                        kerase = 1'b1;
                        lock = pins.addr[3];
                        busy = 3;
                    end
                    8'h70: smode = 1'b1;
                    8'h50, 8'hF0: sr = sr & 8'hC5;
                    default: ;
                endcase
            end
        end
        // a finished read ends the status overlay and ages the algorithm
        if (pins.oe_n === 1'b1 && oe_q === 1'b0) begin
            last = dq_now;
            smode = 1'b0;
            if (busy > 0) begin
                busy = busy - 1;
                if (busy == 0 && kerase && lock) sr = sr | 8'h22;
                if (busy == 0 && kerase && !lock) foreach (arr[i]) arr[i] = 16'hFFFF;
            end
        end
        we_q = pins.we_n;
        oe_q = pins.oe_n;
    end
    always_comb begin
        if (smode) dq_now = {8'hC3, busy == 0, sr[6:1], 1'b1};
        else if (busy > 0) dq_now = {8'h5A, kerase ? 1'b0 : ~pd[7], 7'h11};
        else dq_now = arr[pins.addr[3:0]];
        // no pull on dq: a released bus shows the inverse, not the last word
        dq = (!pins.ce_n && !pins.oe_n) ? dq_now : ~last;
    end
endmodule : fasr_flash_model

// *** flash_algorithm_status_report_bench.sv ***
// flash_algorithm_status_report_bench: apb sequences against the flash model.
// assumes fasr_flash_model on the pins and a 20 MHz pclk.
`timescale 1ns/1ps
module flash_algorithm_status_report_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err;
    logic [15:0] model_q, flash_dq_in;
    logic [15:0] clr [2] = '{16'h0050, 16'h00F0};
    fasr_pkg::fasr_pins_t flash_pins;
    int fail_count = 0, comparisons = 0;
    always #25 pclk = ~pclk;
    assign flash_dq_in = flash_pins.dq_oe_n ? model_q : flash_pins.dq_out;
    fasr_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_dq_in(flash_dq_in), .flash_pins(flash_pins));
    fasr_flash_model flash (.pins(flash_pins), .dq(model_q));
    task automatic close_out;
        $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic give_up(input int n);
        if (n >= 100) begin
            fail_count++;
            $display("FAIL %0t: wait ran out", $time);
            close_out();
        end
    endtask : give_up
    // entered just after an edge; back-to-back setup keeps psel high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        give_up(n);
    endtask : apb
    task automatic run_op(input fasr_pkg::fasr_op_t op, input logic [7:0] a,
        input logic [15:0] w);
        int n;
        n = 0;
        apb(1'b1, fasr_pkg::OFS_ADDR, {24'h00_0000, a});
        apb(1'b1, fasr_pkg::OFS_WDATA, {16'h0000, w});
        apb(1'b1, fasr_pkg::OFS_CTRL, {30'h0000_0000, op});
        do begin
            apb(1'b0, fasr_pkg::OFS_STAT, 32'h0000_0000);
            n++;
        end while (rd[1:0] !== 2'b10 && n < 100);
        give_up(n);
        apb(1'b0, fasr_pkg::OFS_RDATA, 32'h0000_0000);
    endtask : run_op
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, fasr_pkg::OFS_STAT, 32'h0000_0000);
        check(rd & 32'h00FF_0001, 32'h0080_0000);
        run_op(fasr_pkg::FASR_OP_WRITE, 8'h02, 16'h00A0);
        run_op(fasr_pkg::FASR_OP_WRITE, 8'h02, 16'h005A);
        run_op(fasr_pkg::FASR_OP_POLL, 8'h02, 16'h005A);
        check(rd, 32'h0000_005A);
        run_op(fasr_pkg::FASR_OP_WRITE, 8'h03, 16'h00A0);
        run_op(fasr_pkg::FASR_OP_WRITE, 8'h03, 16'h0033);
        run_op(fasr_pkg::FASR_OP_STATUS, 8'h03, 16'h0070);
        check(rd, 32'h0000_0080);
        run_op(fasr_pkg::FASR_OP_READ, 8'h03, 16'h0000);
        check(rd & 32'h0000_FFFF, 32'h0000_0033);
        run_op(fasr_pkg::FASR_OP_WRITE, 8'h01, 16'h0030);
        run_op(fasr_pkg::FASR_OP_POLL, 8'h01, 16'h0080);
        check(rd, 32'h0000_FFFF);
        // locked sector erase, then each clearing command in turn
        foreach (clr[i]) begin
            run_op(fasr_pkg::FASR_OP_WRITE, 8'h08, 16'h0030);
            run_op(fasr_pkg::FASR_OP_POLL, 8'h08, 16'h0080);
            check(rd, 32'h0000_FFFF);
            run_op(fasr_pkg::FASR_OP_STATUS, 8'h08, 16'h0070);
            check(rd, 32'h0000_00A2);
            apb(1'b0, fasr_pkg::OFS_STAT, 32'h0000_0000);
            check(rd & 32'h00FF_0003, 32'h00A2_0002);
            run_op(fasr_pkg::FASR_OP_WRITE, 8'h08, clr[i]);
            run_op(fasr_pkg::FASR_OP_STATUS, 8'h08, 16'h0070);
            check(rd, 32'h0000_0080);
        end
        apb(1'b0, 8'h20, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        close_out();
    end
endmodule : flash_algorithm_status_report_bench
